// >>> daqio_pkg.sv
// daqio_pkg: constants shared by the data acquisition board I/O control block.
// assumes byte-wide I/O accesses of eight consecutive offsets from a switch base.
package daqio_pkg;
	localparam int DAQIO_ADDR_W = 10;
	localparam int DAQIO_BASE_W = 7;
	localparam int DAQIO_OFS_W = 3;
	localparam int DAQIO_CODE_W = 12;
	localparam int DAQIO_CHAN_W = 3;

	localparam logic [2:0] DAQIO_OFS_ADC_LOW = 3'h0;
	localparam logic [2:0] DAQIO_OFS_ADC_HIGH = 3'h1;
	localparam logic [2:0] DAQIO_OFS_STATUS_CTRL = 3'h2;
	localparam logic [2:0] DAQIO_OFS_DIGITAL = 3'h3;
	localparam logic [2:0] DAQIO_OFS_DAC0_LOW = 3'h4;
	localparam logic [2:0] DAQIO_OFS_DAC0_HIGH = 3'h5;
	localparam logic [2:0] DAQIO_OFS_DAC1_LOW = 3'h6;
	localparam logic [2:0] DAQIO_OFS_DAC1_HIGH = 3'h7;

	localparam int DAQIO_BUSY_BIT = 7;
	localparam logic [7:0] DAQIO_BYTE_ZERO = 8'h00;
	localparam logic [11:0] DAQIO_CODE_ZERO = 12'h000;
	localparam logic [2:0] DAQIO_CHAN_ZERO = 3'h0;

	typedef enum logic [2:0] {
		DAQIO_ADC_IDLE = 3'b001,
		DAQIO_ADC_START = 3'b010,
		DAQIO_ADC_WAIT = 3'b100
	} daqio_adc_state_t;
endpackage : daqio_pkg

// >>> daqio_dac_chan.sv
// daqio_dac_chan: one double-buffered 12-bit dac code, low and high bytes into a held stage, copied to an output stage.
// assumes write strobes and the update strobe are single-cycle, from the bus decode.
`timescale 1ns/1ns
`default_nettype none
module daqio_dac_chan
	import daqio_pkg::*;
(
	input wire logic mclk, // bus clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic wrLow, // write strobe for the low byte
	input wire logic wrHigh, // write strobe for the high byte
	input wire logic [7:0] wrData, // bus write data
	input wire logic update, // transfer the held code to the output stage
	output logic [11:0] dacCode // output stage, unsigned straight binary
);
	logic [11:0] heldCode;
	logic [11:0] next_heldCode;
	logic [11:0] next_dacCode;

	always_comb begin
		next_heldCode = heldCode;
		next_dacCode = dacCode;
		if (wrLow) begin
			next_heldCode[7:0] = wrData;
		end
		if (wrHigh) begin
			next_heldCode[11:8] = wrData[3:0];
		end
		// the output stage copies the first stage only on update, so writes never glitch it
		if (update) begin
			next_dacCode = heldCode;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			heldCode <= DAQIO_CODE_ZERO;
			dacCode <= DAQIO_CODE_ZERO;
		end else begin
			heldCode <= next_heldCode;
			dacCode <= next_dacCode;
		end
	end
endmodule : daqio_dac_chan
`default_nettype wire

// >>> daqio_adc_seq.sv
// daqio_adc_seq: conversion sequencing, busy flag and result capture.
// assumes the converter engine answers a start pulse with a one-cycle done and its result.
`timescale 1ns/1ns
`default_nettype none
module daqio_adc_seq
	import daqio_pkg::*;
(
	input wire logic mclk, // bus clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic startReq, // write to the start offset
	input wire logic adcDone, // converter finished, result valid this cycle
	input wire logic [11:0] adcData, // converter result
	output logic adcStart, // start pulse to the converter
	output logic busy, // conversion in progress
	output logic [11:0] result // last completed result
);
	daqio_adc_state_t state;
	daqio_adc_state_t next_state;
	logic next_busy;
	logic next_adcStart;
	logic [11:0] next_result;

	always_comb begin
		next_state = state;
		next_busy = busy;
		next_adcStart = 1'b0;
		next_result = result;
		case (state)
			DAQIO_ADC_IDLE: begin
				if (startReq) begin
					next_state = DAQIO_ADC_START;
					next_busy = 1'b1;
					next_adcStart = 1'b1;
				end
			end
			DAQIO_ADC_START: begin
				next_state = DAQIO_ADC_WAIT;
			end
			DAQIO_ADC_WAIT: begin
				// an overrunning start restarts the converter; the old result is dropped
				if (startReq) begin
					next_state = DAQIO_ADC_START;
					next_adcStart = 1'b1;
				end else if (adcDone) begin
					next_state = DAQIO_ADC_IDLE;
					next_result = adcData;
					next_busy = 1'b0;
				end
			end
			default: begin
				next_state = DAQIO_ADC_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= DAQIO_ADC_IDLE;
			busy <= 1'b0;
			adcStart <= 1'b0;
			result <= DAQIO_CODE_ZERO;
		end else begin
			state <= next_state;
			busy <= next_busy;
			adcStart <= next_adcStart;
			result <= next_result;
		end
	end
endmodule : daqio_adc_seq
`default_nettype wire

// >>> daqio_top.sv
// daqio_top: register decode for the data acquisition board I/O control block.
// assumes one access strobe per cycle on the byte-wide I/O bus, synchronous to mclk.
// Behaviour
// - offset two reads status, writes channel
// - status bit 7 high while converting
// - status bits 2..0 show selected channel
// - offset two write loads channel bits
// - offset three write loads output latch
// - offset three read returns live inputs
// - offset three read updates both dacs
// - dac codes in write-only byte pairs
// - low byte holds code bits 7..0
// - high byte takes bits 3..0 only
// - dac writes move outputs only on update
// - dac code is unsigned straight binary
// - adc result is 12-bit unsigned
// - offset one write starts a conversion
// - result split over offsets one and zero
// - decode eight addresses from switch base
`timescale 1ns/1ns
`default_nettype none
module daqio_top
	import daqio_pkg::*;
(
	input wire logic mclk, // bus clock, 125 MHz
	input wire logic rst_b, // synchronous reset, active low
	input wire logic [DAQIO_ADDR_W-1:0] ioAddr, // I/O address
	input wire logic ioRd, // read strobe, one cycle
	input wire logic ioWr, // write strobe, one cycle
	input wire logic [7:0] ioWrData, // write data
	input wire logic [DAQIO_BASE_W-1:0] baseSwitch, // base address switches
	input wire logic [7:0] digIn, // digital input lines
	input wire logic adcDone, // converter done pulse
	input wire logic [11:0] adcData, // converter result
	output logic [7:0] ioRdData, // read data, valid the cycle after ioRd
	output logic [7:0] digOut, // digital output latch
	output logic [2:0] channelSelect, // analog multiplexer channel
	output logic adcStart, // conversion start pulse
	output logic [11:0] dac0Code, // dac channel 0 output stage
	output logic [11:0] dac1Code // dac channel 1 output stage
);
	logic hit;
	logic [2:0] ofs;
	logic wrEn;
	logic rdEn;
	logic busy;
	logic [11:0] result;
	logic dacUpdate;
	logic [7:0] next_ioRdData;
	logic [7:0] next_digOut;
	logic [2:0] next_channelSelect;

	assign ofs = ioAddr[DAQIO_OFS_W-1:0];
	assign hit = (ioAddr[DAQIO_ADDR_W-1:DAQIO_OFS_W] == baseSwitch);
	assign wrEn = ioWr && hit;
	assign rdEn = ioRd && hit;
	assign dacUpdate = rdEn && (ofs == DAQIO_OFS_DIGITAL);

	always_comb begin
		next_digOut = digOut;
		next_channelSelect = channelSelect;
		next_ioRdData = DAQIO_BYTE_ZERO;
		if (wrEn && ofs == DAQIO_OFS_STATUS_CTRL) begin
			next_channelSelect = ioWrData[DAQIO_CHAN_W-1:0];
		end
		if (wrEn && ofs == DAQIO_OFS_DIGITAL) begin
			next_digOut = ioWrData;
		end
		if (rdEn) begin
			case (ofs)
				DAQIO_OFS_ADC_LOW: begin
					next_ioRdData = {result[3:0], 4'h0};
				end
				DAQIO_OFS_ADC_HIGH: begin
					next_ioRdData = result[11:4];
				end
				DAQIO_OFS_STATUS_CTRL: begin
					// only the channel bits 2..0 of the written control byte are read back
					next_ioRdData = DAQIO_BYTE_ZERO;
					next_ioRdData[DAQIO_BUSY_BIT] = busy;
					next_ioRdData[DAQIO_CHAN_W-1:0] = channelSelect;
				end
				DAQIO_OFS_DIGITAL: begin
					next_ioRdData = digIn;
				end
				default: begin
					// dac offsets are write-only and read as zero
					next_ioRdData = DAQIO_BYTE_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			digOut <= DAQIO_BYTE_ZERO;
			channelSelect <= DAQIO_CHAN_ZERO;
			ioRdData <= DAQIO_BYTE_ZERO;
		end else begin
			digOut <= next_digOut;
			channelSelect <= next_channelSelect;
			ioRdData <= next_ioRdData;
		end
	end

	daqio_adc_seq uAdc (
		.mclk(mclk),
		.rst_b(rst_b),
		.startReq(wrEn && ofs == DAQIO_OFS_ADC_HIGH),
		.adcDone(adcDone),
		.adcData(adcData),
		.adcStart(adcStart),
		.busy(busy),
		.result(result)
	);

	daqio_dac_chan uDac0 (
		.mclk(mclk),
		.rst_b(rst_b),
		.wrLow(wrEn && ofs == DAQIO_OFS_DAC0_LOW),
		.wrHigh(wrEn && ofs == DAQIO_OFS_DAC0_HIGH),
		.wrData(ioWrData),
		.update(dacUpdate),
		.dacCode(dac0Code)
	);

	daqio_dac_chan uDac1 (
		.mclk(mclk),
		.rst_b(rst_b),
		.wrLow(wrEn && ofs == DAQIO_OFS_DAC1_LOW),
		.wrHigh(wrEn && ofs == DAQIO_OFS_DAC1_HIGH),
		.wrData(ioWrData),
		.update(dacUpdate),
		.dacCode(dac1Code)
	);
endmodule : daqio_top
`default_nettype wire

// >>> daqio_top_asserts.sv
// checker on the daqio_top ports.
// assumes one access strobe per cycle.
`timescale 1ns/1ns
`default_nettype none
module daqio_top_asserts
	import daqio_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rst_b, // reset
	input wire logic [DAQIO_ADDR_W-1:0] ioAddr, // addr
	input wire logic ioRd, // rd
	input wire logic ioWr, // wr
	input wire logic [7:0] ioWrData, // wdata
	input wire logic [DAQIO_BASE_W-1:0] baseSwitch, // base
	input wire logic [7:0] digIn, // din
	input wire logic adcDone, // done
	input wire logic [11:0] adcData, // result
	input wire logic [7:0] ioRdData, // rdata
	input wire logic [7:0] digOut, // dout
	input wire logic [2:0] channelSelect, // chan
	input wire logic adcStart, // start
	input wire logic [11:0] dac0Code, // dac0
	input wire logic [11:0] dac1Code // dac1
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic rdH, wrH;
	logic [2:0] ofs;
	assign rdH = ioRd && ioAddr[9:3] == baseSwitch;
	assign wrH = ioWr && ioAddr[9:3] == baseSwitch;
	assign ofs = ioAddr[2:0];
	a_start_pulse: assert property (wrH && ofs == 3'h1 |=> adcStart)
		else $error("start missing");
	a_chan_load: assert property (wrH && ofs == 3'h2 |=> channelSelect == $past(ioWrData[2:0]))
		else $error("channel wrong");
	a_dout_load: assert property (wrH && ofs == 3'h3 |=> digOut == $past(ioWrData))
		else $error("dout wrong");
	a_din_live: assert property (rdH && ofs == 3'h3 |=> ioRdData == $past(digIn))
		else $error("din wrong");
	a_dac_hold: assert property (!(rdH && ofs == 3'h3) |=> $stable({dac0Code, dac1Code}))
		else $error("dac moved");
	a_stat_chan: assert property (rdH && ofs == 3'h2 |=> ioRdData[2:0] == channelSelect)
		else $error("status chan wrong");
	a_stat_spare: assert property (rdH && ofs == 3'h2 |=> ioRdData[6:3] == 4'h0)
		else $error("status spare bits");
	a_dac_rdzero: assert property (rdH && ofs[2] |=> ioRdData == 8'h00)
		else $error("dac read not zero");
	a_rdata_idle: assert property (!rdH |=> ioRdData == 8'h00)
		else $error("read data not idle");
	c_din: cover property (rdH && ofs == 3'h3);
	c_start: cover property (adcStart);
	c_done: cover property (adcDone);
endmodule : daqio_top_asserts
`default_nettype wire

// >>> daqio_conv_model.sv
// converter engine model: done pulse a fixed delay after start.
// assumes adcStart is one cycle; a new start restarts the count.
`timescale 1ns/1ns
`default_nettype none
module daqio_conv_model #(parameter int LAT = 20) (
	input wire logic mclk, // clock
	input wire logic rst_b, // reset
	input wire logic adcStart, // start
	input wire logic [11:0] code, // value
	output logic adcDone, // done
	output logic [11:0] adcData // result
);
	int cnt;
	always @(posedge mclk) begin
		adcDone <= cnt == 1;
		// inverse outside done so a stale result is never mistaken for valid
		adcData <= (cnt == 1) ? code : ~code;
		if (!rst_b)
			cnt <= 0;
		else if (adcStart)
			cnt <= LAT;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule : daqio_conv_model
`default_nettype wire

// >>> daqio_top_tb.sv
// testbench for daqio_top: host byte accesses.
// assumes the converter model answers after 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module daqio_top_tb;
	import daqio_pkg::*;
	localparam logic [6:0] BASE = 7'h60;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:0] ioAddr = 10'h000;
	logic ioRd = 1'b0;
	logic ioWr = 1'b0;
	logic [7:0] ioWrData = 8'h00;
	logic [7:0] digIn = 8'h00;
	logic [11:0] code = 12'h000;
	logic [6:0] bs = BASE;
	logic adcDone, adcStart;
	logic [11:0] adcData, dac0Code, dac1Code;
	logic [7:0] ioRdData, digOut, rdv;
	logic [2:0] channelSelect;
	logic [11:0] codes [2] = '{12'h000, 12'hfa5};
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 mclk = ~mclk;
	daqio_top dut (.mclk(mclk), .rst_b(rst_b), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
		.ioWrData(ioWrData), .baseSwitch(BASE), .digIn(digIn), .adcDone(adcDone),
		.adcData(adcData), .ioRdData(ioRdData), .digOut(digOut), .adcStart(adcStart),
		.channelSelect(channelSelect), .dac0Code(dac0Code), .dac1Code(dac1Code));
	daqio_conv_model #(.LAT(20)) conv (.mclk(mclk), .rst_b(rst_b), .adcStart(adcStart),
		.code(code), .adcDone(adcDone), .adcData(adcData));
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic chkb(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask : chkb
	task automatic acc(input logic w, input logic [2:0] ofs, input logic [7:0] d);
		@(posedge mclk);
		ioAddr <= {bs, ofs};
		ioWrData <= d;
		ioWr <= w;
		ioRd <= !w;
		@(posedge mclk);
		ioWr <= 1'b0;
		ioRd <= 1'b0;
		#1;
		rdv = ioRdData;
	endtask : acc
	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		acc(1'b0, 3'h2, 8'h00);
		chkb("status", 8'h00, rdv);
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, 3'h2, {5'h1f, c[2:0]});
			chkb("chanSel", {5'h00, c[2:0]}, {5'h00, channelSelect});
			acc(1'b0, 3'h2, 8'h00);
			chkb("status", {5'h00, c[2:0]}, rdv);
		end
		acc(1'b1, 3'h3, 8'ha5);
		chkb("digOut", 8'ha5, digOut);
		@(posedge mclk);
		digIn <= 8'h3c;
		acc(1'b0, 3'h3, 8'h00);
		chkb("digIn", 8'h3c, rdv);
		acc(1'b1, 3'h4, 8'h34);
		acc(1'b1, 3'h5, 8'hf2);
		acc(1'b1, 3'h6, 8'hcd);
		acc(1'b1, 3'h7, 8'hab);
		chk("dac0", 12'h000, dac0Code);
		acc(1'b0, 3'h5, 8'h00);
		chkb("dacRead", 8'h00, rdv);
		acc(1'b0, 3'h3, 8'h00);
		chk("dac0", 12'h234, dac0Code);
		chk("dac1", 12'hbcd, dac1Code);
		bs = 7'h61;
		acc(1'b1, 3'h3, 8'h5a);
		chkb("offBase", 8'ha5, digOut);
		bs = BASE;
		foreach (codes[i]) begin
			@(posedge mclk);
			code <= codes[i];
			acc(1'b1, 3'h1, 8'h00);
			acc(1'b0, 3'h2, 8'h00);
			chkb("busy", 8'h87, rdv);
			// idle gap keeps starts apart so the converter is not overrun
			repeat (25) @(posedge mclk);
			acc(1'b0, 3'h2, 8'h00);
			chkb("idle", 8'h07, rdv);
			acc(1'b0, 3'h1, 8'h00);
			chkb("resHigh", codes[i][11:4], rdv);
			acc(1'b0, 3'h0, 8'h00);
			chkb("resLow", {codes[i][3:0], 4'h0}, rdv);
		end
		// a conversion still in flight when reset hits must leave busy clear
		acc(1'b1, 3'h1, 8'h00);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
		chkb("rstOut", 8'h00, digOut);
		chk("rstDac0", 12'h000, dac0Code);
		chk("rstDac", 12'h000, dac1Code);
		acc(1'b0, 3'h2, 8'h00);
		chkb("rstStatus", 8'h00, rdv);
		final_report();
	end
endmodule : daqio_top_tb
bind daqio_top daqio_top_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .ioAddr(ioAddr),
	.ioRd(ioRd), .ioWr(ioWr), .ioWrData(ioWrData), .baseSwitch(baseSwitch), .digIn(digIn),
	.adcDone(adcDone), .adcData(adcData), .ioRdData(ioRdData), .digOut(digOut),
	.channelSelect(channelSelect), .adcStart(adcStart), .dac0Code(dac0Code),
	.dac1Code(dac1Code));
`default_nettype wire
